// File: rtl/channel_ctrl_status.sv
/*
  Control and status register block of one host_to_card channel: run and
  halt control toward the scatter_gather_engine, status logging, interrupt
  masking, completed-descriptor count writeback and performance counters.
  Assumes the engine reports busy and one-cycle event pulses on clk_sys,
  and the register port is driven synchronously with 32-bit accesses.
*/
module channel_ctrl_status
  import h2c_ctrl_pkg::*;
#(
  parameter logic [11:0] SUBSYS_CODE = 12'h5a5, // Arbitrary value
  parameter logic [3:0] CHAN_TARGET = 4'h0,
  parameter bit IS_STREAM = 1'b0,
  parameter int CHAN_NUM = 0,
  parameter logic [7:0] VERSION_CODE = 8'h10, // Arbitrary value
  parameter logic [7:0] ADDR_ALIGN = 8'h01,
  parameter logic [7:0] LEN_GRAN = 8'h01,
  parameter logic [7:0] ADDR_BITS = 8'h40
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire reg_req_t regReq,
  output logic [31:0] regRdata,
  output logic regRvalid,
  // Engine side
  input wire logic engBusy,
  input wire eng_evt_t engEvt,
  output logic engRun,
  output logic nonIncMode,
  output logic cardToHostWbOff,
  // Count writeback
  output logic wbValid,
  input wire logic wbReady,
  output logic [63:0] wbAddr,
  output logic [31:0] wbCount,
  // Interrupt request
  output logic irqReq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CHAN_NUM < 0 || CHAN_NUM > 15) begin : g_chan_chk
    $error("CHAN_NUM must fit in four bits");
  end

  localparam logic [3:0] CHAN_ID = 4'(CHAN_NUM);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Plain, set or clear update of a masked word
  function automatic logic [31:0] applyWr(input logic [31:0] old, input logic [31:0] data,
                                          input logic [1:0] mode, input logic [31:0] keep);
    logic [31:0] r;
    r = old;
    case (mode)
      2'd0: r = data & keep;
      2'd1: r = old | (data & keep);
      2'd2: r = old & ~(data & keep);
      default: r = old;
    endcase
    return r;
  endfunction : applyWr

  // Saturating 42-bit counter step
  function automatic logic [PM_W:0] sat(input logic [PM_W-1:0] c, input logic maxed);
    logic [PM_W:0] r;
    r = {maxed, c};
    if (&c) begin
      r = {1'b1, c};
    end else begin
      r = {maxed, c + 1'b1};
    end
    return r;
  endfunction : sat

  chan_state_t s_q, s_d;
  logic [31:0] identWord, statView, loggedEvt;
  logic runRise, runFall;
  logic wrHit, rdHit;
  logic [PM_W:0] cycNext, datNext;

  assign identWord = {SUBSYS_CODE, CHAN_TARGET, IS_STREAM, 3'b000, CHAN_ID, VERSION_CODE};

  // busy is the live engine state
  assign statView = (s_q.stat & STAT_MASK) | {31'd0, engBusy};

  // ----------------------------------------------------------------
  // Event logging
  // ----------------------------------------------------------------
  // per-flag log enables
  // Each event lands only where its enable bit in control is set
  always_comb begin
    loggedEvt = '0;
    loggedEvt[LSB_DESC +: 5] = engEvt.descFault & s_q.ctrl[LSB_DESC +: 5];
    loggedEvt[LSB_WR +: 5] = engEvt.wrFault & WR_FAULT_MASK & s_q.ctrl[LSB_WR +: 5];
    loggedEvt[LSB_RD +: 5] = engEvt.rdFault & s_q.ctrl[LSB_RD +: 5];
    loggedEvt[BIT_BAD_SIZE] = engEvt.badSize & s_q.ctrl[BIT_BAD_SIZE];
    loggedEvt[BIT_BAD_SIG] = engEvt.badSig & s_q.ctrl[BIT_BAD_SIG];
    loggedEvt[BIT_SKEW] = engEvt.skew & s_q.ctrl[BIT_SKEW];
    // done flag, gated by the done enable
    loggedEvt[BIT_DESC_DONE] = engEvt.descDone & engEvt.descComplete & s_q.ctrl[BIT_DESC_DONE];
    loggedEvt[BIT_DESC_HALT] = engEvt.descDone & engEvt.descStop & s_q.ctrl[BIT_DESC_HALT];
    loggedEvt[BIT_HALT_IDLE] = s_q.idlePend & ~engBusy & s_q.ctrl[BIT_HALT_IDLE];
  end

  // Single-cycle strobes; the port never inserts wait states
  assign wrHit = regReq.wrEn;
  assign rdHit = regReq.rdEn;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    runRise = '0;
    runFall = '0;

    // Register writes; reserved bits masked off
    if (wrHit) begin
      case (regReq.addr)
        OFS_CTRL: s_d.ctrl = applyWr(s_q.ctrl, regReq.wdata, 2'd0, CTRL_MASK);
        OFS_CTRL_SET: s_d.ctrl = applyWr(s_q.ctrl, regReq.wdata, 2'd1, CTRL_MASK & ALIAS_MASK);
        OFS_CTRL_CLR: s_d.ctrl = applyWr(s_q.ctrl, regReq.wdata, 2'd2, CTRL_MASK & ALIAS_MASK);
        OFS_STAT: s_d.stat = applyWr(s_q.stat, regReq.wdata, 2'd2, STAT_MASK);
        OFS_WB_LO: s_d.wbLo = regReq.wdata;
        OFS_WB_HI: s_d.wbHi = regReq.wdata;
        OFS_MASK: s_d.mask = applyWr(s_q.mask, regReq.wdata, 2'd0, STAT_MASK);
        OFS_MASK_SET: s_d.mask = applyWr(s_q.mask, regReq.wdata, 2'd1, STAT_MASK);
        OFS_MASK_CLR: s_d.mask = applyWr(s_q.mask, regReq.wdata, 2'd2, STAT_MASK);
        OFS_PM_CTRL: begin
          s_d.pmCtrl = {regReq.wdata[PM_RUN], 1'b0, regReq.wdata[PM_AUTO]};
        end
        default: s_d.ctrl = s_q.ctrl; // Unmapped: ignored
      endcase
    end

    // Run edges seen on the word about to be registered
    runRise = s_d.ctrl[BIT_RUN] & ~s_q.ctrl[BIT_RUN];
    runFall = ~s_d.ctrl[BIT_RUN] & s_q.ctrl[BIT_RUN];

    // Register reads, one cycle latency
    if (rdHit) begin
      s_d.rvalid = 1'b1;
      case (regReq.addr)
        OFS_IDENT: s_d.rdata = identWord;
        OFS_CTRL: s_d.rdata = s_q.ctrl;
        OFS_STAT: s_d.rdata = statView;
        OFS_STAT_RC: s_d.rdata = statView;
        OFS_DONE_CNT: s_d.rdata = s_q.doneCnt;
        OFS_ALIGN: s_d.rdata = {8'h00, ADDR_ALIGN, LEN_GRAN, ADDR_BITS};
        OFS_WB_LO: s_d.rdata = s_q.wbLo;
        OFS_WB_HI: s_d.rdata = s_q.wbHi;
        OFS_MASK: s_d.rdata = s_q.mask;
        OFS_PM_CTRL: s_d.rdata = {29'd0, s_q.pmCtrl[PM_RUN], 1'b0, s_q.pmCtrl[PM_AUTO]};
        OFS_CYC_LO: s_d.rdata = s_q.cycCnt[31:0];
        OFS_CYC_HI: s_d.rdata = {15'd0, s_q.cycMax, 6'd0, s_q.cycCnt[PM_W-1:32]};
        OFS_DAT_LO: s_d.rdata = s_q.datCnt[31:0];
        OFS_DAT_HI: s_d.rdata = {15'd0, s_q.datMax, 6'd0, s_q.datCnt[PM_W-1:32]};
        default: s_d.rdata = RESET_WORD; // Write-only and unmapped read zero
      endcase
      // read view clears everything but busy
      if (regReq.addr == OFS_STAT_RC) begin
        s_d.stat = s_d.stat & ~STAT_MASK;
      end
    end

    // run set clears flags except skew
    if (runRise) begin
      s_d.stat = s_d.stat & ~RUNCLR_MASK;
      s_d.doneCnt = '0;
      s_d.halted = 1'b0;
      s_d.idlePend = 1'b0;
    end

    // remember a stop request until the engine idles
    if (runFall) begin
      s_d.idlePend = 1'b1;
    end else if (s_q.idlePend & ~engBusy) begin
      s_d.idlePend = 1'b0;
    end

    // New events win over any clear this cycle
    s_d.stat = s_d.stat | loggedEvt;

    if (|loggedEvt[LSB_DESC +: 5] | |loggedEvt[LSB_WR +: 5] | |loggedEvt[LSB_RD +: 5]) begin
      s_d.halted = 1'b1;
    end
    // bad signature always stops the engine
    if (engEvt.badSig) begin
      s_d.halted = 1'b1;
    end

    // Completed descriptor count
    if (engEvt.descDone) begin
      s_d.doneCnt = s_d.doneCnt + 32'd1;
    end

    if (s_q.wbValid & wbReady) begin
      s_d.wbValid = 1'b0;
    end
    if (engEvt.descDone & engEvt.descComplete & s_q.ctrl[BIT_CNT_WB]) begin
      s_d.wbValid = 1'b1;
      s_d.wbCount = s_d.doneCnt;
    end

    // Performance counters; clear and auto-clear reset both cycle and beat counts
    cycNext = sat(s_q.cycCnt, s_q.cycMax);
    datNext = sat(s_q.datCnt, s_q.datMax);
    if (s_q.pmCtrl[PM_RUN] & s_q.ctrl[BIT_RUN]) begin
      {s_d.cycMax, s_d.cycCnt} = cycNext;
      if (engEvt.beat) begin
        {s_d.datMax, s_d.datCnt} = datNext;
      end
    end
    if (s_q.pmCtrl[PM_AUTO] & engEvt.descDone & engEvt.descStop) begin
      s_d.pmCtrl[PM_RUN] = 1'b0;
    end
    if ((wrHit & (regReq.addr == OFS_PM_CTRL) & regReq.wdata[PM_CLEAR]) |
        (s_q.pmCtrl[PM_AUTO] & runRise)) begin
      s_d.cycCnt = '0;
      s_d.cycMax = 1'b0;
      s_d.datCnt = '0;
      s_d.datMax = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // run reaches the engine unless halted
  // dropping run only asks; the engine finishes its descriptor
  assign engRun = s_q.ctrl[BIT_RUN] & ~s_q.halted;
  assign nonIncMode = s_q.ctrl[BIT_NON_INC];
  assign cardToHostWbOff = s_q.ctrl[BIT_CARD_TO_HOST_WB_OFF];
  assign wbValid = s_q.wbValid;
  assign wbAddr = {s_q.wbHi, s_q.wbLo};
  assign wbCount = s_q.wbCount;
  assign regRdata = s_q.rdata;
  assign regRvalid = s_q.rvalid;
  assign irqReq = |(s_q.stat & s_q.mask & STAT_MASK);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_run_start;
    @(posedge clk_sys) disable iff (srst)
      (wrHit && regReq.addr == OFS_CTRL && regReq.wdata[0] && !s_q.ctrl[0]) |=> engRun;
  endproperty
  a_run_start: assert property (p_run_start) else $error("run write did not start engine");

  property p_busy_view;
    @(posedge clk_sys) disable iff (srst)
      (rdHit && regReq.addr == OFS_STAT) |=> (regRdata[0] == $past(engBusy));
  endproperty
  a_busy_view: assert property (p_busy_view) else $error("busy bit wrong");

  property p_fault_halt;
    @(posedge clk_sys) disable iff (srst)
      (engEvt.rdFault[0] && s_q.ctrl[LSB_RD] && !runRise) |=> (!engRun && s_q.stat[LSB_RD]);
  endproperty
  a_fault_halt: assert property (p_fault_halt) else $error("read fault not halted");

  property p_wr_rsvd;
    @(posedge clk_sys) disable iff (srst)
      (engEvt.wrFault[4:2] != 3'b000) |=> (s_q.stat[LSB_WR+2 +: 3] == 3'b000);
  endproperty
  a_wr_rsvd: assert property (p_wr_rsvd) else $error("reserved write fault bit logged");

  property p_sig_halt;
    @(posedge clk_sys) disable iff (srst)
      engEvt.badSig |=> !engRun;
  endproperty
  a_sig_halt: assert property (p_sig_halt) else $error("bad signature did not stop engine");

  property p_no_log_disabled;
    @(posedge clk_sys) disable iff (srst)
      (!s_q.ctrl[BIT_BAD_SIZE] && !s_q.stat[BIT_BAD_SIZE]) |=> !s_q.stat[BIT_BAD_SIZE];
  endproperty
  a_no_log_disabled: assert property (p_no_log_disabled) else $error("flag set while disabled");

  property p_wb;
    @(posedge clk_sys) disable iff (srst)
      (engEvt.descDone && engEvt.descComplete && s_q.ctrl[BIT_CNT_WB]) |=> wbValid;
  endproperty
  a_wb: assert property (p_wb) else $error("writeback not raised");

  property p_count_wb;
    @(posedge clk_sys) disable iff (srst)
      (engEvt.descDone && engEvt.descComplete && s_q.ctrl[BIT_CNT_WB] && !runRise) |=>
        (wbCount == $past(s_q.doneCnt) + 32'd1);
  endproperty
  a_count_wb: assert property (p_count_wb) else $error("written back count wrong");

  property p_set_alias;
    @(posedge clk_sys) disable iff (srst)
      (wrHit && regReq.addr == OFS_CTRL_SET && regReq.wdata[BIT_NON_INC]) |=> nonIncMode;
  endproperty
  a_set_alias: assert property (p_set_alias) else $error("set alias failed");

  property p_clr_alias;
    @(posedge clk_sys) disable iff (srst)
      (wrHit && regReq.addr == OFS_CTRL_CLR && regReq.wdata[BIT_NON_INC]) |=> !nonIncMode;
  endproperty
  a_clr_alias: assert property (p_clr_alias) else $error("clear alias failed");

  property p_run_drop;
    @(posedge clk_sys) disable iff (srst)
      (wrHit && regReq.addr == OFS_CTRL_CLR && regReq.wdata[BIT_RUN]) |=> !engRun;
  endproperty
  a_run_drop: assert property (p_run_drop) else $error("cleared run still reaches engine");

  property p_irq;
    @(posedge clk_sys) disable iff (srst)
      (|(loggedEvt & s_q.mask) && !wrHit) |=> irqReq;
  endproperty
  a_irq: assert property (p_irq) else $error("masked event gave no interrupt");

  property p_run_clears;
    @(posedge clk_sys) disable iff (srst)
      (runRise && !engEvt.descDone && loggedEvt == '0) |=> (s_q.stat[BIT_DESC_DONE] == 1'b0 && s_q.doneCnt == '0);
  endproperty
  a_run_clears: assert property (p_run_clears) else $error("run set did not clear");

  property p_skew_keep;
    @(posedge clk_sys) disable iff (srst)
      (runRise && s_q.stat[BIT_SKEW] && !rdHit) |=> s_q.stat[BIT_SKEW];
  endproperty
  a_skew_keep: assert property (p_skew_keep) else $error("run set cleared skew flag");

  property p_stat_rc;
    @(posedge clk_sys) disable iff (srst)
      (rdHit && regReq.addr == OFS_STAT_RC && loggedEvt == '0) |=> ((s_q.stat & STAT_MASK) == '0);
  endproperty
  a_stat_rc: assert property (p_stat_rc) else $error("read clear left a flag");

  property p_idle_flag;
    @(posedge clk_sys) disable iff (srst)
      (s_q.idlePend && !engBusy && s_q.ctrl[BIT_HALT_IDLE]) |=> s_q.stat[BIT_HALT_IDLE];
  endproperty
  a_idle_flag: assert property (p_idle_flag) else $error("idle flag missed");

  property p_ident;
    @(posedge clk_sys) disable iff (srst)
      (rdHit && regReq.addr == OFS_IDENT) |=> (regRdata[19:8] == {CHAN_TARGET, IS_STREAM, 3'b000, CHAN_ID});
  endproperty
  a_ident: assert property (p_ident) else $error("identifier wrong");

  property p_reserved;
    @(posedge clk_sys) disable iff (srst)
      (s_q.ctrl & ~CTRL_MASK) == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit stored");

  c_halt: cover property (@(posedge clk_sys) disable iff (srst) $fell(engRun) && s_q.halted);
  c_wb: cover property (@(posedge clk_sys) disable iff (srst) wbValid && wbReady);
  c_irq: cover property (@(posedge clk_sys) disable iff (srst) $rose(irqReq));
  c_idle: cover property (@(posedge clk_sys) disable iff (srst) $rose(s_q.stat[BIT_HALT_IDLE]));
  c_fault: cover property (@(posedge clk_sys) disable iff (srst) $rose(|s_q.stat[LSB_DESC +: 5]));

endmodule : channel_ctrl_status

// File: shared/h2c_ctrl_pkg.sv
/*
  Constants, register map and carrier types for the control and status
  logic of one host_to_card scatter_gather_engine channel.
  Assumes a single 32-bit register port with byte offsets in bits 7:0.
*/
// Summary of operation
// - Writing run bit 0 starts the scatter_gather_engine on descriptors.
// - Clearing run lets the current descriptor finish, then transfer stops.
// - Status bit 0 is read-only busy: 1 active, 0 idle.
// - Fault enable fields 23:19, 18:14, 13:9 enable logging and halt on error.
// - Control bits 6..1 enable logging of the same status flag bits.
// - Bit 26 set writes completed count back after a complete-flagged descriptor.
// - Bit 25 selects non-incrementing read addresses on the read channel only.
// - Bit 27 set disables card_to_host stream writeback; clear keeps it on.
// - Writes at 0x08 set control bits 26:0 where data holds ones.
// - Writes at 0x0C clear control bits 26:0 where data holds ones.
// - Interrupt only when a logged status bit and its mask bit are set.
// - Run set clears status 23:1 except skew; writing 1 clears 23:1.
// - Descriptor fault bits: 4 unexp cpl, 3 poisoned, 2 parity, 1 abort, 0 UR.
// - Write fault bits: 1 slave error, 0 decode error, 4:2 reserved.
// - Read fault field uses the same encoding as the descriptor field.
// - Status bit 6 sets when idle after run cleared, if enabled.
// - Status bit 5 flags a stream descriptor length not multiple of width.
// - Invalid signature stops the engine and, if enabled, sets status bit 4.
// - Status bit 3 flags source and destination misaligned to each other.
// - Status bit 2 sets after a complete-flagged descriptor finishes.
// - Status bit 1 sets, if enabled, after a stop-flagged descriptor finishes.
// - Identifier: code 31:20, target 19:16, stream 15, channel 11:8, version 7:0.
package h2c_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_IDENT = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_CTRL_SET = 8'h08;
  localparam logic [7:0] OFS_CTRL_CLR = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h40;
  localparam logic [7:0] OFS_STAT_RC = 8'h44;
  localparam logic [7:0] OFS_DONE_CNT = 8'h48;
  localparam logic [7:0] OFS_ALIGN = 8'h4c;
  localparam logic [7:0] OFS_WB_LO = 8'h88;
  localparam logic [7:0] OFS_WB_HI = 8'h8c;
  localparam logic [7:0] OFS_MASK = 8'h90;
  localparam logic [7:0] OFS_MASK_SET = 8'h94;
  localparam logic [7:0] OFS_MASK_CLR = 8'h98;
  localparam logic [7:0] OFS_PM_CTRL = 8'hc0;
  localparam logic [7:0] OFS_CYC_LO = 8'hc4;
  localparam logic [7:0] OFS_CYC_HI = 8'hc8;
  localparam logic [7:0] OFS_DAT_LO = 8'hcc;
  localparam logic [7:0] OFS_DAT_HI = 8'hd0;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int BIT_RUN = 0;
  localparam int BIT_DESC_HALT = 1;
  localparam int BIT_DESC_DONE = 2;
  localparam int BIT_SKEW = 3;
  localparam int BIT_BAD_SIG = 4;
  localparam int BIT_BAD_SIZE = 5;
  localparam int BIT_HALT_IDLE = 6;
  localparam int LSB_RD = 9;
  localparam int LSB_WR = 14;
  localparam int LSB_DESC = 19;
  localparam int BIT_NON_INC = 25;
  localparam int BIT_CNT_WB = 26;
  localparam int BIT_CARD_TO_HOST_WB_OFF = 27;
  localparam logic [31:0] CTRL_MASK = 32'h0eff_fe7f;
  localparam logic [31:0] ALIAS_MASK = 32'h07ff_ffff;
  localparam logic [31:0] STAT_MASK = 32'h00ff_fe7e;
  localparam logic [31:0] RUNCLR_MASK = 32'h00ff_fe76;
  localparam logic [4:0] WR_FAULT_MASK = 5'h03;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam int PM_RUN = 2;
  localparam int PM_CLEAR = 1;
  localparam int PM_AUTO = 0;
  localparam int PM_W = 42;
  localparam int MAXED_BIT = 16;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic descDone;
    logic descComplete;
    logic descStop;
    logic [4:0] descFault;
    logic [4:0] wrFault;
    logic [4:0] rdFault;
    logic badSize;
    logic badSig;
    logic skew;
    logic beat;
  } eng_evt_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] stat;
    logic [31:0] mask;
    logic [31:0] doneCnt;
    logic [31:0] wbLo;
    logic [31:0] wbHi;
    logic [2:0] pmCtrl;
    logic [PM_W-1:0] cycCnt;
    logic cycMax;
    logic [PM_W-1:0] datCnt;
    logic datMax;
    logic halted;
    logic idlePend;
    logic wbValid;
    logic [31:0] wbCount;
    logic [31:0] rdata;
    logic rvalid;
  } chan_state_t;

endpackage : h2c_ctrl_pkg

// File: tb/channel_ctrl_status_tb.sv
/*
  Self-checking bench for the channel control and status block.
  Assumes the engine model on the far side and a 100 MHz clk_sys.
*/
module channel_ctrl_status_tb
  import h2c_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  reg_req_t regReq = '0;
  eng_evt_t evtReq = '0;
  logic slowReady = 1'b1;
  logic [31:0] regRdata, wbCount;
  logic regRvalid, engBusy, engRun, nonIncMode, cardToHostWbOff, wbValid, wbReady, irqReq;
  eng_evt_t engEvt;
  logic [63:0] wbAddr;
  int err_total = 0;
  int checks_done = 0;
  int lsbs[3] = '{LSB_DESC, LSB_WR, LSB_RD};
  logic [7:0] zeroOfs[6] = '{OFS_CTRL, OFS_STAT, OFS_DONE_CNT, OFS_MASK, 8'h10, 8'h3c};

  always #5 clk_sys = ~clk_sys;

  // ------------------------------------------------------------
  // Design and far side
  // ------------------------------------------------------------
  channel_ctrl_status #(.SUBSYS_CODE(12'h3c3), .IS_STREAM(1'b1), .CHAN_NUM(2), .VERSION_CODE(8'h21),
    .ADDR_ALIGN(8'h40)) u_channel_ctrl_status (
    .clk_sys(clk_sys), .srst(srst), .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid),
    .engBusy(engBusy), .engEvt(engEvt), .engRun(engRun), .nonIncMode(nonIncMode),
    .cardToHostWbOff(cardToHostWbOff), .wbValid(wbValid), .wbReady(wbReady), .wbAddr(wbAddr),
    .wbCount(wbCount), .irqReq(irqReq));
  h2c_engine_model u_h2c_engine_model (.clk_sys(clk_sys), .srst(srst), .evtReq(evtReq),
    .slowReady(slowReady), .engRun(engRun), .wbValid(wbValid), .engBusy(engBusy),
    .engEvt(engEvt), .wbReady(wbReady));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    regReq <= '0;
  endtask : wr

  // Answer is registered on the taking edge, looked at 1 ns after it
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regReq <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk_sys);
    regReq <= '0;
    #1;
    chk("read answer", regRvalid, 1'b1);
    chk($sformatf("reg %h", a), regRdata, e);
  endtask : rchk

  task automatic evt(input eng_evt_t e);
    @(posedge clk_sys);
    evtReq <= e;
    @(posedge clk_sys);
    evtReq <= '0;
  endtask : evt

  // Bounded wait; running out ends the run as a failure
  task automatic waitFor(ref logic sig, input logic lvl);
    for (int i = 0; i < 50 && sig !== lvl; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (sig !== lvl) begin
      err_total++;
      complete_run();
    end
  endtask : waitFor

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [4:0] fexp;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    rchk(OFS_IDENT, 32'h3c30_8221);
    rchk(OFS_ALIGN, 32'h0040_0140);
    foreach (zeroOfs[i]) rchk(zeroOfs[i], 32'h0);
    // Control word and its two aliases
    wr(OFS_CTRL, 32'hffff_ffff);
    rchk(OFS_CTRL, 32'h0eff_fe7f);
    chk("engRun", engRun, 1'b1);
    chk("nonIncMode", nonIncMode, 1'b1);
    chk("cardToHostWbOff", cardToHostWbOff, 1'b1);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL_SET, 32'hffff_ffff);
    rchk(OFS_CTRL, 32'h06ff_fe7f);
    wr(OFS_CTRL_CLR, 32'h0000_0006);
    rchk(OFS_CTRL, 32'h06ff_fe79);
    wr(OFS_CTRL_CLR, 32'hffff_ffff);
    rchk(OFS_CTRL, 32'h0);
    // Completed descriptor with count writeback, slow sink
    wr(OFS_WB_LO, 32'h1000_0040);
    wr(OFS_WB_HI, 32'h0000_0002);
    wr(OFS_MASK, 32'hffff_ffff);
    wr(OFS_MASK_CLR, 32'hffff_fffb);
    rchk(OFS_MASK, 32'h0000_0004);
    wr(OFS_CTRL, 32'h0400_0007);
    evt('{descDone: 1'b1, descComplete: 1'b1, descStop: 1'b1, default: '0});
    rchk(OFS_STAT, 32'h1);
    waitFor(wbValid, 1'b1);
    chk("wbCount", wbCount, 32'h1);
    chk("wbAddr", wbAddr, 64'h0000_0002_1000_0040);
    @(posedge clk_sys);
    #1;
    chk("wbValid", wbValid, 1'b1);
    waitFor(wbValid, 1'b0);
    rchk(OFS_STAT, 32'h6);
    chk("irqReq", irqReq, 1'b1);
    wr(OFS_MASK_CLR, 32'h4);
    rchk(OFS_DONE_CNT, 32'h1);
    chk("irqReq", irqReq, 1'b0);
    rchk(OFS_STAT_RC, 32'h6);
    rchk(OFS_STAT, 32'h0);
    // Run dropped mid-descriptor, prompt sink
    @(posedge clk_sys);
    slowReady <= 1'b0;
    wr(OFS_CTRL_SET, 32'h40);
    evt('{descDone: 1'b1, descComplete: 1'b1, default: '0});
    wr(OFS_CTRL_CLR, 32'h1);
    @(posedge clk_sys);
    #1;
    chk("engRun", engRun, 1'b0);
    chk("engBusy", engBusy, 1'b1);
    waitFor(wbValid, 1'b1);
    chk("wbCount", wbCount, 32'h2);
    waitFor(engBusy, 1'b0);
    repeat (2) @(posedge clk_sys);
    rchk(OFS_STAT, 32'h44);
    wr(OFS_STAT, 32'h44);
    rchk(OFS_STAT, 32'h0);
    // Each fault field: log, halt, clear; write field bits 4:2 stay reserved
    for (int k = 0; k < 3; k++) begin
      fexp = (k == 1) ? 5'h03 : 5'h1f;
      wr(OFS_CTRL, 32'h1 | (32'h1f << lsbs[k]));
      evt(eng_evt_t'(22'h1f << (14 - 5 * k)));
      rchk(OFS_STAT, 32'(fexp) << lsbs[k]);
      chk("engRun", engRun, 1'b0);
      wr(OFS_STAT, 32'hffff_ffff);
      rchk(OFS_STAT, 32'h0);
      wr(OFS_CTRL, 32'h0);
    end
    // Size, signature and skew flags, logged only when enabled
    wr(OFS_CTRL, 32'h1);
    evt('{badSize: 1'b1, badSig: 1'b1, skew: 1'b1, default: '0});
    rchk(OFS_STAT, 32'h0);
    chk("engRun", engRun, 1'b0);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h39);
    evt('{badSize: 1'b1, badSig: 1'b1, skew: 1'b1, default: '0});
    rchk(OFS_STAT, 32'h38);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h39);
    rchk(OFS_STAT, 32'h08);
    // Performance counters: armed for four edges, one data beat
    wr(OFS_PM_CTRL, 32'h7);
    evt('{beat: 1'b1, default: '0});
    wr(OFS_PM_CTRL, 32'h1);
    rchk(OFS_PM_CTRL, 32'h1);
    rchk(OFS_CYC_LO, 32'h4);
    rchk(OFS_CYC_HI, 32'h0);
    rchk(OFS_DAT_LO, 32'h1);
    wr(OFS_PM_CTRL, 32'h2);
    rchk(OFS_CYC_LO, 32'h0);
    rchk(OFS_DAT_LO, 32'h0);
    complete_run();
  end
endmodule : channel_ctrl_status_tb

// File: tb/h2c_engine_model.sv
/*
  Stand-in for the scatter_gather_engine behind the channel block: runs a
  descriptor for four cycles, reports event pulses and sinks count writebacks.
  Assumes the bench raises evtReq for one clk_sys cycle per request.
*/
module h2c_engine_model
  import h2c_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Bench requests
  input wire eng_evt_t evtReq,
  input wire logic slowReady,
  // Block side
  input wire logic engRun,
  input wire logic wbValid,
  output logic engBusy,
  output eng_evt_t engEvt,
  output logic wbReady
);
  timeunit 1ns;
  timeprecision 100ps;
  eng_evt_t held;
  int cnt;
  int wbWait;

  // start, finish
  // A started descriptor always runs out; run low only blocks the next one
  always @(posedge clk_sys) begin
    engEvt <= '0;
    if (srst) begin
      cnt <= 0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        engEvt <= held;
      end
    end else if (evtReq.descDone && engRun) begin
      held <= evtReq;
      cnt <= 4;
    end else begin
      engEvt <= evtReq;
    end
  end

  assign engBusy = (cnt > 0);

  // Writeback sink, prompt or three cycles late
  always @(posedge clk_sys) begin
    if (srst || !wbValid || wbReady) begin
      wbWait <= 0;
      wbReady <= 1'b0;
    end else begin
      wbWait <= wbWait + 1;
      wbReady <= !slowReady || wbWait >= 2;
    end
  end
endmodule : h2c_engine_model
